// File: inc/urm_pkg.sv
// Package: register offsets, field layouts and timing constants for the register-map decode block
package urm_pkg;

    // ==========================================================
    // Register offsets (4-bit register address)
    // ==========================================================
    localparam logic [3:0] OFS_HOLD      = 4'h0; // rx_holding read, tx_holding write
    localparam logic [3:0] OFS_IER       = 4'h1;
    localparam logic [3:0] OFS_FIFO_CTL  = 4'h2; // FIFO control write, interrupt_ident read
    localparam logic [3:0] OFS_LINE_FMT  = 4'h3;
    localparam logic [3:0] OFS_MODEM_CTL = 4'h4;
    localparam logic [3:0] OFS_LSR       = 4'h5;
    localparam logic [3:0] OFS_MSR       = 4'h6;
    localparam logic [3:0] OFS_SPR       = 4'h7;
    localparam logic [3:0] OFS_TX_FIFO_FREE_COUNT     = 4'h8;
    localparam logic [3:0] OFS_RX_FIFO_FILL_COUNT     = 4'h9;
    localparam logic [3:0] OFS_UNUSED    = 4'hD;
    localparam logic [3:0] OFS_SW_RESET  = 4'hE;
    localparam logic [3:0] OFS_EXTRA     = 4'hF;
    localparam logic [3:0] OFS_DIV_LO    = 4'h0;
    localparam logic [3:0] OFS_DIV_HI    = 4'h1;
    localparam logic [3:0] OFS_EFR       = 4'h2;
    localparam logic [3:0] OFS_RESUME_CHAR_FIRST      = 4'h4;
    localparam logic [3:0] OFS_RESUME_CHAR_SECOND      = 4'h5;
    localparam logic [3:0] OFS_PAUSE_CHAR_FIRST     = 4'h6;
    localparam logic [3:0] OFS_PAUSE_CHAR_SECOND     = 4'h7;

    // ==========================================================
    // Bank selection and field positions
    // ==========================================================
    localparam logic [7:0] LCR_ENH_KEY   = 8'hBF; // Opens the enhanced bank
    localparam int         LCR_DIV_BIT   = 7;
    localparam int         MCR_TCR_BIT   = 2;
    localparam int         SWRST_BIT     = 3;
    localparam int         FCR_EN_BIT    = 0;
    localparam int         FCR_RXCLR_BIT = 1;
    localparam int         FCR_TXCLR_BIT = 2;
    localparam int         FCR_TXTRIG_LSB = 4; // Two-bit transmit trigger field
    localparam int         FCR_RXTRIG_LSB = 6; // Two-bit receive trigger field
    localparam logic [7:0] IER_GATED     = 8'hF0; // Writable only with enhanced functions on
    localparam logic [7:0] MCR_GATED     = 8'hE4;
    localparam logic [7:0] MCR_RSVD      = 8'h09;
    localparam logic [7:0] EXTRA_LINE_FEATURES_RSVD     = 8'h48;
    localparam logic [7:0] ZERO_BYTE     = 8'h00;

    // ==========================================================
    // FIFO clear timing: crystal clock is ref_clk here
    // ==========================================================
    localparam int         CLK_PERIOD_NS    = 10;
    localparam int         XTAL_PERIOD_NS   = 10;
    localparam int         FIFO_CLR_XTALS   = 2;
    localparam int         FIFO_CLR_NS      = FIFO_CLR_XTALS * XTAL_PERIOD_NS;
    localparam int         FIFO_CLR_CYC_INT = (FIFO_CLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] FIFO_CLR_CYC     = FIFO_CLR_CYC_INT[1:0];
    localparam logic [1:0] CNT_ONE          = 2'h1;
    localparam logic [1:0] CNT_ZERO         = 2'h0;

    // ==========================================================
    // Field layouts
    // ==========================================================
    typedef struct packed {
        logic       auto_cts;
        logic       auto_rts;
        logic       spec_char;
        logic       enh_en;
        logic [3:0] sw_flow;
    } urm_efr_t;

    typedef struct packed {
        logic irda;
        logic rsvd6;
        logic rts_invert;
        logic rts_dir;
        logic rsvd3;
        logic tx_disable;
        logic rx_disable;
        logic nine_bit;
    } urm_extra_line_features_t;

    typedef struct packed {
        logic fifo_data_err;
        logic tx_all_empty;
        logic thr_empty;
        logic break_seen;
        logic framing_err;
        logic parity_err;
        logic overrun;
        logic rx_ready;
    } urm_lsr_t;

    typedef struct packed {
        logic [7:0] div_lo;
        logic [7:0] div_hi;
        logic [7:0] ier;
        logic [7:0] line_format_ctl;
        logic [7:0] modem_line_ctl;
        logic       fifo_en;
        logic [1:0] rx_trig;
        logic [1:0] tx_trig;
        urm_efr_t   enhanced_features;
        logic [7:0] resume_first;
        logic [7:0] resume_second;
        logic [7:0] pause_first;
        logic [7:0] pause_second;
        logic [7:0] thresholds;
        logic [7:0] trig_levels;
        urm_extra_line_features_t  extra_features;
    } urm_cfg_t;

    typedef struct packed {
        urm_lsr_t   line_status;
        logic [7:0] interrupt_ident;
        logic [7:0] rx_holding;
        logic [7:0] tx_free_count;
        logic [7:0] rx_fill_count;
    } urm_stat_t;

endpackage

// File: design/urm_sync.sv
// Two-flop synchroniser for one level crossing into ref_clk
`timescale 1ns/10ps
module urm_sync (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Level in and out
    input  wire logic din,
    output logic      dout
);
    typedef struct packed {
        logic first;
        logic second;
    } urm_sync_t;

    urm_sync_t state_reg;
    urm_sync_t state_next;

    // First stage is read only by the second stage
    always_comb begin
        state_next.first  = din;
        state_next.second = state_reg.first;
    end

    // Clears to zero, so a constant high input doubles as a reset release
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign dout = state_reg.second;
endmodule

// File: design/urm_regmap.sv
// Register-map decode and access gating for the serial-port bridge
`timescale 1ns/10ps
module urm_regmap (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               arst_n,
    // Register port from the serial front end (same clock)
    input  wire logic [3:0]         reg_addr,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    input  wire logic [7:0]         reg_wdata,
    output logic      [7:0]         reg_rdata,
    output logic                    reg_rvalid,
    // UART core status and CTS pin
    input  wire urm_pkg::urm_stat_t core_stat,
    input  wire logic               cts_pin,
    // Configuration and strobes to the UART core
    output urm_pkg::urm_cfg_t       cfg,
    output logic                    tx_push,
    output logic      [7:0]         tx_data,
    output logic                    rx_pop,
    output logic                    ident_pop,
    output logic                    tx_fifo_clr,
    output logic                    rx_fifo_clr,
    output logic                    sw_reset
);
    typedef struct packed {
        urm_pkg::urm_cfg_t cfg;
        logic [7:0]        scratch;
        logic              cts_prev;
        logic              cts_delta;
        logic [1:0]        tx_clr_cnt;
        logic [1:0]        rx_clr_cnt;
        logic              tx_clr;
        logic              rx_clr;
        logic [7:0]        rdata;
        logic              rvalid;
        logic              tx_push;
        logic [7:0]        tx_data;
        logic              rx_pop;
        logic              ident_pop;
        logic              sw_reset;
    } urm_state_t;

    urm_state_t state_reg;
    urm_state_t state_next;
    logic       rst_n;
    logic       cts_sync;
    logic       bank_gen;
    logic       bank_div;
    logic       bank_enh;
    logic       tcr_sel;
    logic       enh_on;

    // ==========================================================
    // Reset release and CTS pin synchronisers
    // ==========================================================
    urm_sync u_rst_sync (
        .ref_clk (ref_clk),
        .rst_n   (arst_n),
        .din     (1'b1),
        .dout    (rst_n)
    );

    urm_sync u_cts_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .din     (cts_pin),
        .dout    (cts_sync)
    );

    // ==========================================================
    // Bank selection
    // ==========================================================
    // Decoded from the held line-format value, so a bank flips on the write after
    assign bank_gen = !state_reg.cfg.line_format_ctl[urm_pkg::LCR_DIV_BIT];
    assign bank_enh = state_reg.cfg.line_format_ctl == urm_pkg::LCR_ENH_KEY;
    assign bank_div = !bank_gen && !bank_enh;
    assign enh_on   = state_reg.cfg.enhanced_features.enh_en;
    assign tcr_sel  = enh_on && state_reg.cfg.modem_line_ctl[urm_pkg::MCR_TCR_BIT];

    // ==========================================================
    // Next-state logic: writes, reads, strobes, FIFO clear timers
    // ==========================================================
    always_comb begin
        state_next           = state_reg;
        state_next.rvalid    = 1'b0;
        state_next.tx_push   = 1'b0;
        state_next.rx_pop    = 1'b0;
        state_next.ident_pop = 1'b0;
        state_next.sw_reset  = 1'b0;
        // FIFO clear timers count down to zero
        if (state_reg.tx_clr_cnt != urm_pkg::CNT_ZERO) begin
            state_next.tx_clr_cnt = state_reg.tx_clr_cnt - urm_pkg::CNT_ONE;
        end
        if (state_reg.rx_clr_cnt != urm_pkg::CNT_ZERO) begin
            state_next.rx_clr_cnt = state_reg.rx_clr_cnt - urm_pkg::CNT_ONE;
        end
        // Writes; the format register stays reachable so software can always leave a bank
        if (reg_wr) begin
            if (reg_addr == urm_pkg::OFS_LINE_FMT) begin
                state_next.cfg.line_format_ctl = reg_wdata;
            end else if (bank_gen && reg_addr == urm_pkg::OFS_HOLD) begin
                state_next.tx_push = 1'b1;
                state_next.tx_data = reg_wdata;
            end else if (bank_gen && reg_addr == urm_pkg::OFS_IER) begin
                state_next.cfg.ier = enh_on ? reg_wdata
                    : (reg_wdata & ~urm_pkg::IER_GATED) | (state_reg.cfg.ier & urm_pkg::IER_GATED);
            end else if (bank_gen && reg_addr == urm_pkg::OFS_FIFO_CTL) begin
                state_next.cfg.fifo_en = reg_wdata[urm_pkg::FCR_EN_BIT];
                state_next.cfg.rx_trig = reg_wdata[urm_pkg::FCR_RXTRIG_LSB +: 2];
                if (enh_on) begin
                    state_next.cfg.tx_trig = reg_wdata[urm_pkg::FCR_TXTRIG_LSB +: 2];
                end
                // Clear held for the full minimum so the FIFO logic always completes
                if (reg_wdata[urm_pkg::FCR_TXCLR_BIT]) begin
                    state_next.tx_clr_cnt = urm_pkg::FIFO_CLR_CYC;
                end
                if (reg_wdata[urm_pkg::FCR_RXCLR_BIT]) begin
                    state_next.rx_clr_cnt = urm_pkg::FIFO_CLR_CYC;
                end
            end else if (bank_gen && reg_addr == urm_pkg::OFS_MODEM_CTL) begin
                state_next.cfg.modem_line_ctl = (enh_on ? reg_wdata
                    : (reg_wdata & ~urm_pkg::MCR_GATED) | (state_reg.cfg.modem_line_ctl & urm_pkg::MCR_GATED))
                    & ~urm_pkg::MCR_RSVD;
            end else if (bank_gen && reg_addr == urm_pkg::OFS_MSR && tcr_sel) begin
                state_next.cfg.thresholds = reg_wdata;
            end else if (bank_gen && reg_addr == urm_pkg::OFS_SPR) begin
                if (tcr_sel) begin
                    state_next.cfg.trig_levels = reg_wdata;
                end else begin
                    state_next.scratch = reg_wdata;
                end
            end else if (bank_gen && reg_addr == urm_pkg::OFS_SW_RESET) begin
                state_next.sw_reset = reg_wdata[urm_pkg::SWRST_BIT];
            end else if (bank_gen && reg_addr == urm_pkg::OFS_EXTRA) begin
                state_next.cfg.extra_features = reg_wdata & ~urm_pkg::EXTRA_LINE_FEATURES_RSVD;
            end else if (bank_div && reg_addr == urm_pkg::OFS_DIV_LO) begin
                state_next.cfg.div_lo = reg_wdata;
            end else if (bank_div && reg_addr == urm_pkg::OFS_DIV_HI) begin
                state_next.cfg.div_hi = reg_wdata;
            end else if (bank_enh && reg_addr == urm_pkg::OFS_EFR) begin
                state_next.cfg.enhanced_features = reg_wdata;
            end else if (bank_enh && reg_addr == urm_pkg::OFS_RESUME_CHAR_FIRST) begin
                state_next.cfg.resume_first = reg_wdata;
            end else if (bank_enh && reg_addr == urm_pkg::OFS_RESUME_CHAR_SECOND) begin
                state_next.cfg.resume_second = reg_wdata;
            end else if (bank_enh && reg_addr == urm_pkg::OFS_PAUSE_CHAR_FIRST) begin
                state_next.cfg.pause_first = reg_wdata;
            end else if (bank_enh && reg_addr == urm_pkg::OFS_PAUSE_CHAR_SECOND) begin
                state_next.cfg.pause_second = reg_wdata;
            end
        end
        // Reads; anything unmapped in the current bank answers zero
        if (reg_rd) begin
            state_next.rvalid = 1'b1;
            state_next.rdata  = urm_pkg::ZERO_BYTE;
            if (reg_addr == urm_pkg::OFS_LINE_FMT) begin
                state_next.rdata = state_reg.cfg.line_format_ctl;
            end else if (bank_gen && reg_addr == urm_pkg::OFS_HOLD) begin
                state_next.rdata  = core_stat.rx_holding;
                state_next.rx_pop = 1'b1;
            end else if (bank_gen && reg_addr == urm_pkg::OFS_IER) begin
                state_next.rdata = state_reg.cfg.ier;
            end else if (bank_gen && reg_addr == urm_pkg::OFS_FIFO_CTL) begin
                // One pop per read; the host keeps these reads apart
                state_next.rdata     = core_stat.interrupt_ident;
                state_next.ident_pop = 1'b1;
            end else if (bank_gen && reg_addr == urm_pkg::OFS_MODEM_CTL) begin
                state_next.rdata = state_reg.cfg.modem_line_ctl;
            end else if (bank_gen && reg_addr == urm_pkg::OFS_LSR) begin
                state_next.rdata = core_stat.line_status;
            end else if (bank_gen && reg_addr == urm_pkg::OFS_MSR) begin
                if (tcr_sel) begin
                    state_next.rdata = state_reg.cfg.thresholds;
                end else begin
                    state_next.rdata     = {3'h0, state_reg.cts_prev, 3'h0, state_reg.cts_delta};
                    state_next.cts_delta = 1'b0;
                end
            end else if (bank_gen && reg_addr == urm_pkg::OFS_SPR) begin
                state_next.rdata = tcr_sel ? state_reg.cfg.trig_levels : state_reg.scratch;
            end else if (bank_gen && reg_addr == urm_pkg::OFS_TX_FIFO_FREE_COUNT) begin
                state_next.rdata = core_stat.tx_free_count;
            end else if (bank_gen && reg_addr == urm_pkg::OFS_RX_FIFO_FILL_COUNT) begin
                state_next.rdata = core_stat.rx_fill_count;
            end else if (bank_gen && reg_addr == urm_pkg::OFS_EXTRA) begin
                state_next.rdata = state_reg.cfg.extra_features;
            end else if (bank_div && reg_addr == urm_pkg::OFS_DIV_LO) begin
                state_next.rdata = state_reg.cfg.div_lo;
            end else if (bank_div && reg_addr == urm_pkg::OFS_DIV_HI) begin
                state_next.rdata = state_reg.cfg.div_hi;
            end else if (bank_enh && reg_addr == urm_pkg::OFS_EFR) begin
                state_next.rdata = state_reg.cfg.enhanced_features;
            end else if (bank_enh && reg_addr == urm_pkg::OFS_RESUME_CHAR_FIRST) begin
                state_next.rdata = state_reg.cfg.resume_first;
            end else if (bank_enh && reg_addr == urm_pkg::OFS_RESUME_CHAR_SECOND) begin
                state_next.rdata = state_reg.cfg.resume_second;
            end else if (bank_enh && reg_addr == urm_pkg::OFS_PAUSE_CHAR_FIRST) begin
                state_next.rdata = state_reg.cfg.pause_first;
            end else if (bank_enh && reg_addr == urm_pkg::OFS_PAUSE_CHAR_SECOND) begin
                state_next.rdata = state_reg.cfg.pause_second;
            end
        end
        // CTS change sets the delta after any read clear, so the event wins
        state_next.cts_prev = cts_sync;
        if (cts_sync != state_reg.cts_prev) begin
            state_next.cts_delta = 1'b1;
        end
        // Software reset returns configuration to defaults, leaving the divisor alone
        if (state_reg.sw_reset) begin
            state_next.cfg        = '0;
            state_next.cfg.div_lo = state_reg.cfg.div_lo;
            state_next.cfg.div_hi = state_reg.cfg.div_hi;
            state_next.tx_clr_cnt = urm_pkg::FIFO_CLR_CYC;
            state_next.rx_clr_cnt = urm_pkg::FIFO_CLR_CYC;
        end
        state_next.tx_clr = state_next.tx_clr_cnt != urm_pkg::CNT_ZERO;
        state_next.rx_clr = state_next.rx_clr_cnt != urm_pkg::CNT_ZERO;
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Outputs, all straight from the state register
    // ==========================================================
    assign reg_rdata   = state_reg.rdata;
    assign reg_rvalid  = state_reg.rvalid;
    assign cfg         = state_reg.cfg;
    assign tx_push     = state_reg.tx_push;
    assign tx_data     = state_reg.tx_data;
    assign rx_pop      = state_reg.rx_pop;
    assign ident_pop   = state_reg.ident_pop;
    assign tx_fifo_clr = state_reg.tx_clr;
    assign rx_fifo_clr = state_reg.rx_clr;
    assign sw_reset    = state_reg.sw_reset;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_gen_bank_gate: assert property (
        reg_wr && reg_addr == urm_pkg::OFS_SPR && !bank_gen |=> $stable(state_reg.scratch))
        else $error("scratch written outside general bank");

    a_tcr_swap: assert property (
        reg_rd && reg_addr == urm_pkg::OFS_MSR && bank_gen && tcr_sel && !reg_wr
        |=> reg_rvalid && reg_rdata == $past(state_reg.cfg.thresholds))
        else $error("threshold register not returned at its offset");

    a_div_write: assert property (
        reg_wr && reg_addr == urm_pkg::OFS_DIV_LO && bank_div && !state_reg.sw_reset
        |=> cfg.div_lo == $past(reg_wdata))
        else $error("divisor low byte not written");

    a_enh_bank_gate: assert property (
        reg_wr && reg_addr == urm_pkg::OFS_EFR && !bank_enh && !state_reg.sw_reset
        |=> $stable(cfg.enhanced_features))
        else $error("enhanced features written outside enhanced bank");

    a_ier_gate: assert property (
        reg_wr && reg_addr == urm_pkg::OFS_IER && bank_gen && !enh_on && !state_reg.sw_reset
        |=> (cfg.ier & urm_pkg::IER_GATED) == ($past(cfg.ier) & urm_pkg::IER_GATED))
        else $error("gated interrupt-enable bits changed");

    a_fifo_clr_len: assert property (
        $rose(tx_fifo_clr) |-> tx_fifo_clr ##1 tx_fifo_clr)
        else $error("transmit FIFO clear shorter than two cycles");

    a_lsr_read: assert property (
        reg_rd && reg_addr == urm_pkg::OFS_LSR && bank_gen
        |=> reg_rvalid && reg_rdata == $past(core_stat.line_status))
        else $error("line status read mismatch");

    a_extra_line_features_rsvd: assert property (
        (cfg.extra_features & urm_pkg::EXTRA_LINE_FEATURES_RSVD) == urm_pkg::ZERO_BYTE)
        else $error("reserved extra-feature bits set");

    a_cts_delta: assert property (
        $changed(cts_sync) |=> state_reg.cts_delta ##1 1'b1)
        else $error("CTS change lost");
endmodule

// File: sim/urm_host_mdl.sv
// Host model: one register access at a time on the same-clock port
`timescale 1ns/10ps
module urm_host_mdl (
    // Clock
    input  wire logic       ref_clk,
    // Register port towards the device
    output logic      [3:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata
);
    // ==========================================
    // Access task
    // Idle port at time zero; strobes never stretched, so identity reads never burst
    initial begin
        reg_addr = 4'h0; reg_wr = 1'b0; reg_rd = 1'b0; reg_wdata = 8'h00;
    end
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wr    <= w;
        reg_rd    <= !w;
        reg_wdata <= (a == 4'hE) ? (d & 8'h08) : (a == 4'hF) ? (d & 8'hB7) : d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        // Data access must wait out a FIFO clear
        if (w && a == 4'h2 && (d & 8'h06) != 8'h00) repeat (2) @(posedge ref_clk);
    endtask
endmodule

// File: sim/uart_register_map_decode_tb_top.sv
// Self-checking testbench for the register-map decode block
`timescale 1ns/10ps
module uart_register_map_decode_tb_top;
    logic               ref_clk = 1'b0;
    logic               arst_n = 1'b0;
    logic               cts_pin = 1'b0;
    urm_pkg::urm_stat_t core_stat = '0;
    urm_pkg::urm_cfg_t  cfg;
    wire logic [3:0]    reg_addr;
    wire logic          reg_wr, reg_rd;
    wire logic [7:0]    reg_wdata;
    logic      [7:0]    reg_rdata, sv, v, tx_data;
    logic               reg_rvalid, tx_clr, rx_clr, tx_push, rx_pop, ident_pop, sw_rst;
    int                 error_cnt = 0, checks_done = 0, cyc = 0, tx_n = 0, rx_n = 0;
    // ==========================================
    // Clock, models, counters
    always #5 ref_clk = ~ref_clk;
    urm_host_mdl host_u (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
                         .reg_wdata(reg_wdata));
    urm_regmap dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .core_stat(core_stat),
        .cts_pin(cts_pin), .cfg(cfg), .tx_push(tx_push), .tx_data(tx_data),
        .rx_pop(rx_pop), .ident_pop(ident_pop),
        .tx_fifo_clr(tx_clr), .rx_fifo_clr(rx_clr), .sw_reset(sw_rst));
    // Clear lengths counted in cycles; hang guard well above the run length
    always @(posedge ref_clk) begin
        tx_n <= tx_n + int'(tx_clr);
        rx_n <= rx_n + int'(rx_clr);
        cyc  <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            complete_run();
        end
    end
    // ==========================================
    // Tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        host_u.acc(1'b1, a, d);
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        host_u.acc(1'b0, a, 8'h00);
        #1 chk({reg_rvalid, reg_rdata}, {1'b1, e}, "read data");
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        sv = 8'($urandom(32'hac5e4958));
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        cts_pin <= 1'($urandom);
        core_stat <= {$urandom, 8'($urandom)};
        repeat (3) @(posedge ref_clk);
        // General bank: scratch, status, levels, unused slot
        wr(4'h7, sv);
        rd(4'h7, sv);
        rd(4'h5, core_stat.line_status);
        rd(4'h8, core_stat.tx_free_count);
        rd(4'h9, core_stat.rx_fill_count);
        rd(4'hD, 8'h00);
        // Holding and identity accesses raise their one-cycle strobes
        v = 8'($urandom);
        wr(4'h0, v);
        chk({tx_push, tx_data}, {1'b1, v}, "tx push");
        rd(4'h0, core_stat.rx_holding);
        chk(rx_pop, 1'b1, "rx pop");
        rd(4'h2, core_stat.interrupt_ident);
        chk(ident_pop, 1'b1, "ident pop");
        // Clear any stale delta, then a CTS edge shows once in modem status
        host_u.acc(1'b0, 4'h6, 8'h00);
        cts_pin <= ~cts_pin;
        repeat (4) @(posedge ref_clk);
        rd(4'h6, {3'h0, cts_pin, 3'h0, 1'b1});
        rd(4'h6, {3'h0, cts_pin, 4'h0});
        $display("general bank test done");
        // Divisor bank hides the general set
        v = 8'($urandom);
        wr(4'h3, 8'h80);
        wr(4'h0, v);
        chk(tx_push, 1'b0, "no push in divisor bank");
        wr(4'h1, ~v);
        chk({cfg.div_hi, cfg.div_lo}, {~v, v}, "divisor");
        rd(4'h1, ~v);
        rd(4'h7, 8'h00);
        $display("divisor bank test done");
        // Enhanced bank: features and flow characters, divisor hidden
        v = 8'($urandom) | 8'h10;
        wr(4'h3, 8'hBF);
        wr(4'h2, v);
        chk(cfg.enhanced_features, v, "enhanced fields");
        rd(4'h0, 8'h00);
        chk(rx_pop, 1'b0, "no pop in enhanced bank");
        for (int i = 4; i < 8; i++) wr(i[3:0], v + 8'(i));
        for (int i = 4; i < 8; i++) rd(i[3:0], v + 8'(i));
        chk(cfg.pause_second, v + 8'h07, "pause char");
        // Thresholds replace modem status while both enables are set
        wr(4'h3, 8'h03);
        wr(4'h4, 8'h04);
        wr(4'h6, ~sv);
        rd(4'h6, ~sv);
        wr(4'h1, 8'hFF);
        chk(cfg.ier, 8'hFF, "ier open");
        wr(4'h2, 8'h90);
        chk({cfg.rx_trig, cfg.tx_trig}, 4'h9, "triggers open");
        // Enhanced functions off: gated bits frozen, scratch back at 0x07
        wr(4'h3, 8'hBF);
        wr(4'h2, 8'h00);
        wr(4'h3, 8'h03);
        wr(4'h1, 8'h00);
        chk(cfg.ier, 8'hF0, "ier gated");
        rd(4'h7, sv);
        wr(4'h2, 8'h37);
        repeat (2) @(posedge ref_clk);
        #1 chk({cfg.tx_trig, cfg.fifo_en}, 3'b011, "fifo control");
        chk({tx_n[7:0], rx_n[7:0]}, 16'h0202, "clear length");
        $display("gating test done");
        // Software reset also clears both FIFOs
        wr(4'hE, 8'hFF);
        chk(sw_rst, 1'b1, "software reset pulse");
        repeat (4) @(posedge ref_clk);
        #1 chk({tx_n[7:0], rx_n[7:0]}, 16'h0404, "reset clears");
        rd(4'h7, sv);
        $display("software reset test done");
        complete_run();
    end
endmodule
